// ### ufc_regs.vh
// register map, field positions, reset values and timing constants of the serial port
`ifndef UFC_REGS_VH
`define UFC_REGS_VH

// byte offsets on the register bus
`define UFC_A_CTRL 8'h00
`define UFC_A_BAUD 8'h04
`define UFC_A_DATA 8'h08
`define UFC_A_STAT 8'h0c
`define UFC_A_MASK 8'h10
`define UFC_A_LEVEL 8'h14
`define UFC_A_TMO 8'h18
`define UFC_A_RXLEN 8'h1c
`define UFC_A_TXCNT 8'h20
`define UFC_A_CMD 8'h24
`define UFC_A_DIV 8'h28

// control and command register fields
`define UFC_CF_PEN 2
`define UFC_CF_ODD 3
`define UFC_CF_STOP2 4
`define UFC_CF_RTS 5
`define UFC_CF_CTS 6
`define UFC_CF_EN 7
`define UFC_CMD_BRK 0

// status and mask register fields
`define UFC_ST_RX 0
`define UFC_ST_TXD 1
`define UFC_ST_PERR 2
`define UFC_ST_FERR 3
`define UFC_ST_OVR 4
`define UFC_ST_CFG 5
`define UFC_ST_TMO 6

// reset values
`define UFC_CTRL_RST 8'h01
`define UFC_BAUD_RST 32'h0000_2580
`define UFC_TMO_RST 32'h0000_03e8
`define UFC_RXLEN_RST 7'h40

// timing: clock rate, one millisecond in microseconds, break length in bits, 5 percent as 1/20
`define UFC_CLK_HZ 32'h0262_5a00
`define UFC_MS_US 1000
`define UFC_BRK_BITS 4'hd
`define UFC_TOL_DEN 38'h00_0000_0014

`endif

// ### ufc_target.sv
// model of the serial target on the far side of the data and flow pins
`timescale 1ns/10ps
`default_nettype none

module ufc_target #(
  parameter int DIV = 10
) (
  // bench clock
  input wire logic clk,
  // pins of the port
  input wire logic txd,
  input wire logic req_n,
  input wire logic req_oe,
  output logic rxd,
  output logic clr_n
);
  int w = 8;
  int nb = 10;
  logic pen = 1'b0;
  logic odd = 1'b0;
  logic [13:0] rx_frame = 14'h0;
  int rx_count = 0;

  // idle line high; clear into the port asserted
  initial begin
    rxd = 1'b1;
    clr_n = 1'b0;
  end

  // same format as the port's control byte
  task cfg(input logic [7:0] c);
    w = 7 + c[1:0];
    pen = c[2];
    odd = c[3];
    nb = 2 + w + pen + c[4];
  endtask

  // frame lsb first, start in bit 0; bad flips parity
  function automatic logic [13:0] frame(input logic [8:0] d, input logic bad);
    logic [13:0] f;
    logic p;
    f = 14'h0;
    p = odd ^ bad;
    for (int i = 0; i < w; i++) begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    if (pen) f[w + 1] = p;
    for (int i = w + 1 + pen; i < nb; i++) f[i] = 1'b1;
    return f;
  endfunction

  // wait while the request pin says stop
  task send(input logic [8:0] d, input logic bad);
    logic [13:0] f;
    int n;
    f = frame(d, bad);
    for (n = 0; req_oe && req_n && n < 3000; n++) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge clk);
    end
  endtask

  // sample mid-bit; skip the wait after the last bit
  always @(negedge txd) begin : rx_b
    logic [13:0] f;
    f = 14'h0;
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      if (i < nb - 1) repeat (DIV) @(posedge clk);
    end
    rx_frame = f;
    rx_count++;
  end
endmodule  // ufc_target
`default_nettype wire

// ### ufc_uart.v
// serial transmitter and receiver with hardware flow control on an ahb-lite slave
// Contract
// - characters are seven, eight or nine bits on both transmit and receive
// - parity absent, even (0) or odd (1); generated on transmit, checked on receive
// - one or two stop bits per transmitted character, as configured
// - no parity allows 8/9 bits, parity allows 7/8; other settings rejected
// - configuration error when derived baud misses the request by over five percent
// - break holds the transmit line low for thirteen bit periods, then idles
// - nine-bit characters travel as two bytes, low byte first; else one byte
// - receive buffer depth set in characters, default 64; zero disables buffering
// - count of received bytes waiting is readable at any time
// - flow control none, request output, clear input, or both; only those pins used
// - request output is active low; clear input is active low, idle high
// - with clear input enabled, no new character starts while the input is high
// - a character handed over while not clear waits inside, sent once clear
// - full buffer plus arriving character deasserts the request output
// - overflow character held aside, uncounted; moves in and reasserts on a read
// - unbuffered: each received character deasserts the request output until read
// - first and inter-character timeouts in ms, plus a count of accepted bytes
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ufc_regs.vh"

module ufc_uart #(
  parameter [31:0] CLK_HZ = `UFC_CLK_HZ,
  parameter [31:0] MS_CYC = `UFC_CLK_HZ / 1000000 * `UFC_MS_US,
  parameter [6:0] DEPTH = `UFC_RXLEN_RST,
  parameter AW = 6
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // serial lines
  input wire rxd,
  output reg txd,
  // flow control pins
  output reg ready_to_receive_out_n,
  output reg rts_oe,
  input wire clear_to_send_in_n,
  // interrupt
  output reg irq
);

  // character width from the two-bit width code: 7, 8 or 9
  function [3:0] ufc_nbits;
    input [1:0] c;
    begin
      ufc_nbits = 4'd7 + {2'd0, c};
    end
  endfunction

  // mask of the low n data bits
  function [8:0] ufc_mask;
    input [3:0] n;
    begin
      ufc_mask = ~(9'h1ff << n);
    end
  endfunction

  // legal width and parity pairs
  function ufc_combo_ok;
    input [7:0] c;
    begin
      if (c[`UFC_CF_PEN])
        ufc_combo_ok = (c[1:0] == 2'd0) || (c[1:0] == 2'd1);
      else
        ufc_combo_ok = (c[1:0] == 2'd1) || (c[1:0] == 2'd2);
    end
  endfunction

  // whole transmit frame, bit 0 first on the line; unused top bits stay high
  function [12:0] ufc_frame;
    input [8:0] d;
    input [7:0] c;
    integer i;
    reg [3:0] n;
    begin
      n = ufc_nbits(c[1:0]);
      ufc_frame = 13'h1ffe;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n)
          ufc_frame[i + 1] = d[i];
      end
      if (c[`UFC_CF_PEN])
        ufc_frame[n + 4'd1] = ^(d & ufc_mask(n)) ^ c[`UFC_CF_ODD];
    end
  endfunction

  // configuration state
  reg [7:0] ctrl_q;
  reg [31:0] baud_q;
  reg [31:0] div_q;
  reg cfg_ok_q;
  reg [31:0] tmo_q;
  reg [6:0] rxlen_q;
  reg [15:0] txcnt_q;
  reg [6:0] stat_q;
  reg [6:0] mask_q;
  // bus phase
  reg ph_v_q;
  reg ph_w_q;
  reg ph_un_q;
  reg [5:0] ph_a_q;
  // baud divider calculation
  reg calc_q;
  reg chk_q;
  reg [4:0] ccnt_q;
  reg [31:0] dvd_q;
  reg [31:0] quo_q;
  reg [32:0] rem_q;
  // transmitter
  reg [12:0] tsh_q;
  reg [3:0] tbits_q;
  reg [31:0] tcyc_q;
  reg tbusy_q;
  reg hold_v_q;
  reg [8:0] hold_q;
  reg lo_v_q;
  reg [7:0] lo_q;
  reg brk_q;
  // receiver
  reg [1:0] rst_q;
  reg [31:0] rcyc_q;
  reg [3:0] rn_q;
  reg [10:0] rsh_q;
  reg rdone_q;
  // receive buffer
  reg [8:0] mem [0:(1 << AW) - 1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  reg side_v_q;
  reg [8:0] side_q;
  reg half_q;
  // millisecond timing
  reg [31:0] mcnt_q;
  reg [15:0] idle_q;

  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS = 2'd2;

  // decoded configuration
  wire [3:0] nb = ufc_nbits(ctrl_q[1:0]);
  wire nine = (ctrl_q[1:0] == 2'd2);
  wire pen = ctrl_q[`UFC_CF_PEN];
  wire rts_sel = ctrl_q[`UFC_CF_RTS];
  wire cts_sel = ctrl_q[`UFC_CF_CTS];
  wire run = ctrl_q[`UFC_CF_EN] & cfg_ok_q;

  // bus strobes: writes land in the data phase, reads one cycle later with a wait state
  wire accept = hsel & htrans[1] & hready;
  wire wr = ph_v_q & ph_w_q & ~ph_un_q;
  wire rd = ph_v_q & ~ph_w_q & ~ph_un_q;
  wire [7:0] pa = {ph_a_q, 2'b00};
  wire w_ctrl = wr & (pa == `UFC_A_CTRL);
  wire w_baud = wr & (pa == `UFC_A_BAUD);
  wire w_data = wr & (pa == `UFC_A_DATA);
  wire w_mask = wr & (pa == `UFC_A_MASK);
  wire w_tmo = wr & (pa == `UFC_A_TMO);
  wire w_rxlen = wr & (pa == `UFC_A_RXLEN);
  wire w_txcnt = wr & (pa == `UFC_A_TXCNT);
  wire w_cmd = wr & (pa == `UFC_A_CMD);
  wire r_data = rd & (pa == `UFC_A_DATA);
  wire r_stat = rd & (pa == `UFC_A_STAT);

  // divider quality check: rounded quotient and error against the request
  wire [32:0] rem_sh = {rem_q[31:0], dvd_q[31]};
  wire rem_ge = rem_sh >= {1'b0, baud_q};
  wire rnd = {rem_q[31:0], 1'b0} >= {1'b0, baud_q};
  wire [32:0] err = rnd ? ({1'b0, baud_q} - rem_q) : rem_q;
  wire [32:0] prod = {1'b0, CLK_HZ} - rem_q + (rnd ? {1'b0, baud_q} : 33'd0);
  wire [31:0] qdiv = quo_q + {31'd0, rnd};
  wire [37:0] err20 = {5'd0, err} * `UFC_TOL_DEN;
  wire baud_good = (baud_q != 32'd0) && (qdiv >= 32'd2) && (err20 <= {5'd0, prod});

  // transmit start: break first, then a held character once the clear input allows
  wire cts_ok = ~cts_sel | ~clear_to_send_in_n;
  wire tx_go = run & ~tbusy_q & (brk_q | (hold_v_q & cts_ok));
  wire tx_bit_end = tbusy_q & (tcyc_q == div_q - 32'd1);
  wire [12:0] tx_fr = ufc_frame(hold_q, ctrl_q);
  wire [3:0] tx_len = 4'd2 + nb + {3'd0, pen} + {3'd0, ctrl_q[`UFC_CF_STOP2]};
  wire tx_take = w_data & ~hold_v_q;

  // receive frame decode, valid in the cycle of rdone_q
  wire [3:0] rx_m = nb + {3'd0, pen} + 4'd1;
  wire [10:0] rx_fr = rsh_q >> (4'd11 - rx_m);
  wire [8:0] rx_ch = rx_fr[8:0] & ufc_mask(nb);
  wire rx_perr = pen & (rx_fr[nb] != (^rx_ch ^ ctrl_q[`UFC_CF_ODD]));
  wire rx_ferr = ~rsh_q[10];

  // buffer bookkeeping
  wire [6:0] cap = (rxlen_q == 7'd0) ? 7'd1 : rxlen_q;
  wire full = ({{(6-AW){1'b0}}, cnt_q} >= cap);
  wire nonempty = (cnt_q != {(AW+1){1'b0}});
  wire pop = r_data & nonempty & (~nine | half_q);
  wire mv_side = pop & side_v_q;
  wire rx_in = rdone_q & (~full | pop) & ~mv_side;
  wire rx_side = rdone_q & ~rx_in & rts_sel & (rxlen_q != 7'd0) & (~side_v_q | mv_side);
  wire rx_ovr = rdone_q & ~rx_in & ~rx_side;
  wire push = rx_in | mv_side;
  wire [8:0] rd_ch = mem[rp_q];
  wire [7:0] rd_byte = (nine & half_q) ? {7'd0, rd_ch[8]} : rd_ch[7:0];
  wire [7:0] lvl = nine ? ({cnt_q, 1'b0} - {7'd0, half_q}) : {1'b0, cnt_q};

  // millisecond tick and the idle-time timeouts
  wire ms_tick = (mcnt_q == MS_CYC - 32'd1);
  wire [15:0] idle_nx = idle_q + 16'd1;
  wire tmo_tx = hold_v_q & ~tbusy_q & (idle_nx == tmo_q[15:0]);
  wire tmo_rx = nonempty & (tmo_q[31:16] != 16'd0) & (idle_nx == tmo_q[31:16]);
  wire ev_tmo = ms_tick & (tmo_tx | tmo_rx);

  // events and sticky status; a new event beats the clearing read
  wire [6:0] ev = {ev_tmo, 1'b0, rx_ovr, rdone_q & rx_ferr, rdone_q & rx_perr,
                   tx_bit_end & (tbits_q == 4'd1), rdone_q};
  wire bad_ctrl = w_ctrl & ~ufc_combo_ok(hwdata[7:0]);
  wire bad_baud = chk_q & ~baud_good;
  wire [6:0] ev_all = ev | {1'b0, bad_ctrl | bad_baud, 5'd0};
  wire [6:0] stat_d = (stat_q & ~{7{r_stat}}) | ev_all;

  // read data mux
  reg [31:0] rmux;
  always @* begin
    case (pa)
      `UFC_A_CTRL: rmux = {24'd0, ctrl_q};
      `UFC_A_BAUD: rmux = baud_q;
      `UFC_A_DATA: rmux = nonempty ? {24'd0, rd_byte} : 32'd0;
      `UFC_A_STAT: rmux = {25'd0, stat_q};
      `UFC_A_MASK: rmux = {25'd0, mask_q};
      `UFC_A_LEVEL: rmux = {17'd0, ~ready_to_receive_out_n, clear_to_send_in_n, calc_q,
                            cfg_ok_q, side_v_q, tbusy_q, hold_v_q, lvl};
      `UFC_A_TMO: rmux = tmo_q;
      `UFC_A_RXLEN: rmux = {25'd0, rxlen_q};
      `UFC_A_TXCNT: rmux = {16'd0, txcnt_q};
      `UFC_A_DIV: rmux = div_q;
      default: rmux = 32'd0;
    endcase
  end

  // ahb-lite slave: zero-wait writes, one wait state on reads, always okay
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_v_q <= 1'b0;
      ph_w_q <= 1'b0;
      ph_un_q <= 1'b0;
      ph_a_q <= 6'd0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'd0;
    end else begin
      if (accept) begin
        ph_v_q <= 1'b1;
        ph_w_q <= hwrite;
        ph_un_q <= |haddr[31:8];
        ph_a_q <= haddr[7:2];
        hreadyout <= hwrite;
      end else if (ph_v_q) begin
        ph_v_q <= 1'b0;
        hreadyout <= 1'b1;
      end
      if (ph_v_q & ~ph_w_q)
        hrdata <= ph_un_q ? 32'd0 : rmux;
    end
  end

  // software registers, status and interrupt
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `UFC_CTRL_RST;
      mask_q <= 7'd0;
      tmo_q <= `UFC_TMO_RST;
      rxlen_q <= `UFC_RXLEN_RST;
      stat_q <= 7'd0;
      irq <= 1'b0;
      rts_oe <= 1'b0;
      ready_to_receive_out_n <= 1'b1;
    end else begin
      if (w_ctrl & ufc_combo_ok(hwdata[7:0]))
        ctrl_q <= hwdata[7:0];
      if (w_mask)
        mask_q <= hwdata[6:0];
      if (w_tmo)
        tmo_q <= hwdata;
      if (w_rxlen)
        rxlen_q <= (hwdata[6:0] > DEPTH) ? DEPTH : hwdata[6:0];
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
      // only a selected request pin is driven; unselected it rests at not-ready
      rts_oe <= rts_sel;
      ready_to_receive_out_n <= ~rts_sel | side_v_q
                                | ((rxlen_q == 7'd0) & nonempty);
    end
  end

  // baud divider: clock rate over requested rate by restoring division, 32 steps
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baud_q <= `UFC_BAUD_RST;
      calc_q <= 1'b1;
      chk_q <= 1'b0;
      ccnt_q <= 5'd0;
      dvd_q <= CLK_HZ;
      quo_q <= 32'd0;
      rem_q <= 33'd0;
      div_q <= 32'd2;
      cfg_ok_q <= 1'b0;
    end else begin
      chk_q <= 1'b0;
      if (w_baud) begin
        baud_q <= hwdata;
        calc_q <= 1'b1;
        ccnt_q <= 5'd0;
        dvd_q <= CLK_HZ;
        quo_q <= 32'd0;
        rem_q <= 33'd0;
        cfg_ok_q <= 1'b0;
      end else if (calc_q) begin
        rem_q <= rem_ge ? (rem_sh - {1'b0, baud_q}) : rem_sh;
        quo_q <= {quo_q[30:0], rem_ge};
        dvd_q <= {dvd_q[30:0], 1'b0};
        ccnt_q <= ccnt_q + 5'd1;
        if (ccnt_q == 5'd31) begin
          calc_q <= 1'b0;
          chk_q <= 1'b1;
        end
      end else if (chk_q) begin
        // a miss keeps the old divider but holds the port disabled
        cfg_ok_q <= baud_good;
        if (baud_good)
          div_q <= qdiv;
      end
    end
  end

  // transmitter: holding register, low-byte latch for nine-bit pairs, frame shifter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_v_q <= 1'b0;
      hold_q <= 9'd0;
      lo_v_q <= 1'b0;
      lo_q <= 8'd0;
      txcnt_q <= 16'd0;
      brk_q <= 1'b0;
      tbusy_q <= 1'b0;
      tsh_q <= 13'h1fff;
      tbits_q <= 4'd0;
      tcyc_q <= 32'd0;
      txd <= 1'b1;
    end else begin
      if (w_cmd & hwdata[`UFC_CMD_BRK])
        brk_q <= 1'b1;
      if (w_txcnt)
        txcnt_q <= 16'd0;
      else if (tx_take)
        txcnt_q <= txcnt_q + 16'd1;
      if (tx_take) begin
        if (nine & ~lo_v_q) begin
          lo_q <= hwdata[7:0];
          lo_v_q <= 1'b1;
        end else begin
          hold_q <= nine ? {hwdata[0], lo_q} : {1'b0, hwdata[7:0]};
          hold_v_q <= 1'b1;
          lo_v_q <= 1'b0;
        end
      end
      if (tx_go) begin
        tbusy_q <= 1'b1;
        tcyc_q <= 32'd0;
        if (brk_q) begin
          brk_q <= 1'b0;
          tsh_q <= 13'h0000;
          tbits_q <= `UFC_BRK_BITS;
          txd <= 1'b0;
        end else begin
          hold_v_q <= 1'b0;
          tsh_q <= tx_fr;
          tbits_q <= tx_len;
          txd <= tx_fr[0];
        end
      end else if (tbusy_q) begin
        if (tx_bit_end) begin
          tcyc_q <= 32'd0;
          tsh_q <= {1'b1, tsh_q[12:1]};
          tbits_q <= tbits_q - 4'd1;
          if (tbits_q == 4'd1) begin
            tbusy_q <= 1'b0;
            txd <= 1'b1;
          end else begin
            txd <= tsh_q[1];
          end
        end else begin
          tcyc_q <= tcyc_q + 32'd1;
        end
      end
    end
  end

  // receiver: start bit checked at mid-bit, then one sample per bit period
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= RX_IDLE;
      rcyc_q <= 32'd0;
      rn_q <= 4'd0;
      rsh_q <= 11'h7ff;
      rdone_q <= 1'b0;
    end else begin
      rdone_q <= 1'b0;
      case (rst_q)
        RX_IDLE: begin
          rcyc_q <= 32'd0;
          if (run & ~rxd)
            rst_q <= RX_START;
        end
        RX_START: begin
          if (rcyc_q == {1'b0, div_q[31:1]}) begin
            rcyc_q <= 32'd0;
            rn_q <= 4'd0;
            // a high line at mid start bit is a glitch, not a character
            rst_q <= rxd ? RX_IDLE : RX_BITS;
          end else begin
            rcyc_q <= rcyc_q + 32'd1;
          end
        end
        RX_BITS: begin
          if (rcyc_q == div_q - 32'd1) begin
            rcyc_q <= 32'd0;
            rsh_q <= {rxd, rsh_q[10:1]};
            rn_q <= rn_q + 4'd1;
            if (rn_q == rx_m - 4'd1) begin
              rdone_q <= 1'b1;
              rst_q <= RX_IDLE;
            end
          end else begin
            rcyc_q <= rcyc_q + 32'd1;
          end
        end
        default: rst_q <= RX_IDLE;
      endcase
    end
  end

  // receive buffer storage; the side slot moves in ahead of any new character
  always @(posedge clk) begin
    if (push)
      mem[wp_q] <= mv_side ? side_q : rx_ch;
  end

  // receive buffer pointers, count, side slot and the nine-bit read half
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      side_v_q <= 1'b0;
      side_q <= 9'd0;
      half_q <= 1'b0;
    end else begin
      if (push)
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      if (rx_side) begin
        side_v_q <= 1'b1;
        side_q <= rx_ch;
      end else if (mv_side) begin
        side_v_q <= 1'b0;
      end
      if (pop)
        half_q <= 1'b0;
      else if (r_data & nonempty & nine)
        half_q <= 1'b1;
    end
  end

  // millisecond divider and idle time since the last transmit start, received character or data write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcnt_q <= 32'd0;
      idle_q <= 16'd0;
    end else begin
      mcnt_q <= ms_tick ? 32'd0 : mcnt_q + 32'd1;
      if (tx_go | rdone_q | tx_take)
        idle_q <= 16'd0;
      else if (ms_tick & (idle_q != 16'hffff))
        idle_q <= idle_nx;
    end
  end

endmodule // ufc_uart

`default_nettype wire

// ### ufc_uart_props.sv
// pin-level assertions for the serial port with flow control
`timescale 1ns/10ps
`default_nettype none

module ufc_uart_props #(
  parameter int LOW_MAX = 130  // 13 bits at 10 cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // serial and flow pins
  input wire logic txd,
  input wire logic ready_to_receive_out_n,
  input wire logic rts_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // transfers taken on the bus
  wire logic rd_go = hsel & htrans[1] & hready & ~hwrite;
  wire logic wr_go = hsel & htrans[1] & hready & hwrite;
  int low_cnt;

  // current low run; only a break runs this long
  always @(posedge clk or negedge nrst) begin
    if (!nrst) low_cnt <= 0;
    else if (txd) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end

  sequence s_rd;
    rd_go;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (s_rd |=> s_one_wait)
    else $error("read did not take one wait state");
  a_write_nowait: assert property (wr_go |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_go))
    else $error("wait state without a read");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read");
  a_req_idle: assert property ((!rts_oe) [*2] |-> ready_to_receive_out_n)
    else $error("request pin asserted with flow off");
  a_break_len: assert property (low_cnt <= LOW_MAX)
    else $error("transmit line low too long");
  a_start_len: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  cover property (low_cnt == LOW_MAX);
endmodule  // ufc_uart_props

bind ufc_uart ufc_uart_props u_ufc_uart_props (.clk(clk), .nrst(nrst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txd(txd),
  .ready_to_receive_out_n(ready_to_receive_out_n), .rts_oe(rts_oe));
`default_nettype wire

// ### ufc_uart_test.sv
// self-checking bench for the serial port with flow control
`timescale 1ns/10ps
`default_nettype none
`include "ufc_regs.vh"

module ufc_uart_test;
  logic clk, nrst, hsel, hwrite, rxd, txd, req_n, rts_oe, clr_n, irq, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int err_count = 0;
  int n_compared = 0;
  // 7E1 7O2 8N1 8O1 9N2 9N1, enabled
  localparam logic [7:0] CF [6] = '{8'h84, 8'h9c, 8'h81, 8'h8d, 8'h92, 8'h82};

  // four-deep buffer keeps runs short
  ufc_uart #(.DEPTH(7'd4), .AW(2)) u_ufc_uart (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .txd(txd), .ready_to_receive_out_n(req_n),
    .rts_oe(rts_oe), .clear_to_send_in_n(clr_n), .irq(irq));
  ufc_target u_ufc_target (.clk(clk), .txd(txd), .req_n(req_n),
    .req_oe(rts_oe), .rxd(rxd), .clr_n(clr_n));

  // 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tmo;
    err_count++;
    give_verdict;
  endtask

  // bounded wait for hreadyout
  task tick_rdy;
    int n;
    for (n = 0; n == 0 || (hreadyout !== 1'b1 && n < 20); n++) @(posedge clk);
    if (n == 20) tmo;
  endtask

  // address phase, then data phase; data taken at its end
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    tick_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    tick_rdy;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, {24'h0, a}, 32'h0);
    check(rd & m, e);
  endtask

  // reread until the masked value shows
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n == 0 || ((rd & m) !== v && n < 400); n++) bus(1'b0, {24'h0, a}, 32'h0);
    if (n == 400) tmo;
  endtask

  task wait_rx(input int c);
    int n;
    for (n = 0; u_ufc_target.rx_count < c && n < 3000; n++) @(posedge clk);
    if (n == 3000) tmo;
    repeat (10) @(posedge clk);
  endtask

  task t_reset;
    check(32'({txd, req_n, rts_oe, irq, hresp}), 32'h18);
    rdc(`UFC_A_CTRL, 32'hff, 32'h01);
    rdc(`UFC_A_TMO, 32'hffff_ffff, 32'h3e8);
    wr(8'h2c, 32'hffff_ffff);
    rdc(8'h2c, 32'hffff_ffff, 32'h0);
    bus(1'b0, 32'h100, 32'h0);
    check(rd, 32'h0);
  endtask

  task t_baud;
    poll(`UFC_A_LEVEL, 32'h800, 32'h800);
    wr(`UFC_A_BAUD, 32'd15000000);
    poll(`UFC_A_STAT, 32'h20, 32'h20);
    rdc(`UFC_A_LEVEL, 32'h800, 32'h0);
    wr(`UFC_A_BAUD, 32'd4000000);
    poll(`UFC_A_LEVEL, 32'h800, 32'h800);
    rdc(`UFC_A_DIV, 32'hffff_ffff, 32'd10);
  endtask

  // illegal width and parity pairs leave the control byte alone
  task t_ctrl;
    logic [7:0] prev, c;
    logic ok;
    prev = 8'h01;
    for (int i = 0; i < 6; i++) begin
      c = {5'h0, i[0], i[2:1]};
      ok = i[0] ? (i[2:1] != 2) : (i[2:1] != 0);
      wr(`UFC_A_CTRL, c);
      rdc(`UFC_A_CTRL, 32'hff, ok ? c : prev);
      rdc(`UFC_A_STAT, 32'h20, ok ? 32'h0 : 32'h20);
      if (ok) prev = c;
    end
  endtask

  task t_tx;
    logic [8:0] d;
    int k;
    wr(`UFC_A_TXCNT, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = 9'h12c + 9'(i * 29);
      u_ufc_target.cfg(CF[i]);
      wr(`UFC_A_CTRL, CF[i]);
      k = u_ufc_target.rx_count;
      wr(`UFC_A_DATA, {24'h0, d[7:0]});
      if (CF[i][1]) wr(`UFC_A_DATA, {31'h0, d[8]});
      wait_rx(k + 1);
      check(32'(u_ufc_target.rx_frame), 32'(u_ufc_target.frame(d, 1'b0)));
    end
    rdc(`UFC_A_TXCNT, 32'hff, 32'd8);
  endtask

  task t_rx;
    u_ufc_target.cfg(8'h82);
    wr(`UFC_A_CTRL, 32'h82);
    u_ufc_target.send(9'h15a, 1'b0);
    poll(`UFC_A_LEVEL, 32'hff, 32'd2);
    rdc(`UFC_A_DATA, 32'hff, 32'h5a);
    rdc(`UFC_A_LEVEL, 32'hff, 32'd1);
    rdc(`UFC_A_DATA, 32'h1ff, 32'h1);
    rdc(`UFC_A_STAT, 32'h0c, 32'h0);
    u_ufc_target.cfg(8'h85);
    wr(`UFC_A_CTRL, 32'h85);
    u_ufc_target.send(9'h03c, 1'b1);
    poll(`UFC_A_LEVEL, 32'hff, 32'd1);
    rdc(`UFC_A_STAT, 32'h05, 32'h05);
    rdc(`UFC_A_DATA, 32'hff, 32'h3c);
  endtask

  // held-off clear input stalls a character; ignored with flow off
  task t_cts;
    int n, k;
    u_ufc_target.cfg(8'hc1);
    u_ufc_target.clr_n <= 1'b1;
    wr(`UFC_A_CTRL, 32'hc1);
    k = u_ufc_target.rx_count;
    wr(`UFC_A_DATA, 32'h96);
    n = 0;
    repeat (300) @(posedge clk) if (txd !== 1'b1) n++;
    check(32'(n), 32'h0);
    rdc(`UFC_A_LEVEL, 32'h2100, 32'h2100);
    u_ufc_target.clr_n <= 1'b0;
    wait_rx(k + 1);
    check(32'(u_ufc_target.rx_frame), 32'(u_ufc_target.frame(9'h96, 1'b0)));
    u_ufc_target.clr_n <= 1'b1;
    wr(`UFC_A_CTRL, 32'h81);
    wr(`UFC_A_DATA, 32'h69);
    wait_rx(k + 2);
    check(32'(u_ufc_target.rx_frame), 32'(u_ufc_target.frame(9'h69, 1'b0)));
    u_ufc_target.clr_n <= 1'b0;
  endtask

  task t_rts;
    wr(`UFC_A_RXLEN, 32'd4);
    wr(`UFC_A_CTRL, 32'ha1);
    repeat (2) @(posedge clk);
    check(32'({rts_oe, req_n}), 32'h2);
    for (int i = 0; i < 5; i++) u_ufc_target.send(9'h040 + 9'(i), 1'b0);
    poll(`UFC_A_LEVEL, 32'h4ff, 32'h404);
    check(32'(req_n), 32'h1);
    rdc(`UFC_A_DATA, 32'hff, 32'h40);
    poll(`UFC_A_LEVEL, 32'h4ff, 32'h004);
    repeat (2) @(posedge clk);
    check(32'(req_n), 32'h0);
    for (int i = 1; i < 5; i++) rdc(`UFC_A_DATA, 32'hff, 32'h40 + i);
    rdc(`UFC_A_LEVEL, 32'hff, 32'h0);
    wr(`UFC_A_RXLEN, 32'd0);
    u_ufc_target.send(9'h077, 1'b0);
    poll(`UFC_A_LEVEL, 32'hff, 32'd1);
    check(32'(req_n), 32'h1);
    rdc(`UFC_A_DATA, 32'hff, 32'h77);
    repeat (3) @(posedge clk);
    check(32'(req_n), 32'h0);
    wr(`UFC_A_CTRL, 32'h81);
    repeat (2) @(posedge clk);
    check(32'({rts_oe, req_n}), 32'h1);
  endtask

  // count the sampled low cycles of a break
  task t_brk;
    int n, m;
    wr(`UFC_A_CMD, 32'h1);
    for (n = 0; txd !== 1'b0 && n < 200; n++) @(posedge clk);
    for (m = 0; txd === 1'b0 && m < 300; m++) @(posedge clk);
    check(32'(m), 32'd130);
  endtask

  // unmasked frame-done raises irq; a status read drops it
  task t_irq;
    int n;
    wr(`UFC_A_MASK, 32'h2);
    rdc(`UFC_A_STAT, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(`UFC_A_DATA, 32'h33);
    for (n = 0; irq !== 1'b1 && n < 300; n++) @(posedge clk);
    check(32'(irq), 32'h1);
    rdc(`UFC_A_STAT, 32'h2, 32'h2);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(`UFC_A_MASK, 32'h0);
    wr(`UFC_A_DATA, 32'h44);
    repeat (150) @(posedge clk);
    check(32'(irq), 32'h0);
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_baud;
    t_ctrl;
    t_tx;
    t_rx;
    t_cts;
    t_rts;
    t_brk;
    t_irq;
    give_verdict;
  end
endmodule  // ufc_uart_test
`default_nettype wire
